// ===== core/srs_pkg.sv
// Purpose: Constants and types for the refresh scheduler
// Assumes: 100 MHz system clock, eight banks
// Notes:   Times are kept in their own units, cycle counts derived

package srs_pkg;

	// ==========================================================
	// Clock and geometry
	localparam int CLK_PERIOD_NS = 10;
	localparam int NUM_BANKS     = 8;
	localparam int BANK_W        = 3;
	localparam int SINCE_W       = 8;
	localparam int IVL_W         = 10;
	localparam int CREDIT_W      = 14;
	localparam int OWED_W        = 4;
	localparam int WIN_W         = 32;

	// ==========================================================
	// Refresh timing
	localparam int  RFC_AB_NS    = 130;
	localparam int  RFC_PB_NS    = 60;
	localparam int  REFW_COOL_MS = 32;
	localparam int  REFW_HOT_MS  = 8;
	localparam real REFI_AB_US   = 3.9;
	localparam real REFI_PB_US   = 0.4875;
	localparam real REFBW_US     = 4.16;
	localparam int  BURST_MAX    = 8;

	localparam logic [SINCE_W-1:0] RFC_AB_CYC =
		SINCE_W'((RFC_AB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [SINCE_W-1:0] RFC_PB_CYC =
		SINCE_W'((RFC_PB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int REFBW_CYC = int'(REFBW_US * 1000.0) / CLK_PERIOD_NS;
	// One extra cycle so a ninth refresh can never share a closed window
	localparam logic [SINCE_W-1:0] BURST_GAP_CYC = SINCE_W'(REFBW_CYC / BURST_MAX + 1);

	localparam int REFW_COOL_CYC = REFW_COOL_MS * 1000000 / CLK_PERIOD_NS;
	localparam int REFW_HOT_CYC  = REFW_HOT_MS * 1000000 / CLK_PERIOD_NS;

	localparam logic [CREDIT_W-1:0] REF_COUNT = 14'h2000;

	localparam logic [IVL_W-1:0] REFI_AB_COOL_CYC =
		IVL_W'(int'(REFI_AB_US * 1000.0) / CLK_PERIOD_NS);
	localparam logic [IVL_W-1:0] REFI_PB_COOL_CYC =
		IVL_W'(int'(REFI_PB_US * 1000.0) / CLK_PERIOD_NS);
	localparam logic [IVL_W-1:0] REFI_AB_HOT_CYC =
		IVL_W'(REFW_HOT_MS * 1000000 / 8192 / CLK_PERIOD_NS);
	localparam logic [IVL_W-1:0] REFI_PB_HOT_CYC =
		IVL_W'(REFW_HOT_MS * 1000000 / 8192 / NUM_BANKS / CLK_PERIOD_NS);

	localparam logic [OWED_W-1:0] OWED_MAX = 4'h8;

	// ==========================================================
	// Temperature and command encoding
	localparam logic [2:0] TEMP_RATE_NOMINAL = 3'h3;
	localparam int         CA_SCOPE_BIT      = 3;
	localparam logic [3:0] CA_REF_AB         = 4'hC;
	localparam logic [3:0] CA_REF_PB         = 4'h4;
	localparam logic [3:0] CA_IDLE           = 4'h0;
	localparam logic [BANK_W-1:0] LAST_BANK  = 3'h7;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		PH_DIST  = 3'b001,
		PH_BURST = 3'b010,
		PH_PAUSE = 3'b100
	} srs_phase_t;

	typedef struct packed {
		logic       cs_n;
		logic [3:0] ca;
	} srs_cmd_t;

	typedef struct packed {
		logic              valid;
		logic [BANK_W-1:0] bank;
	} srs_act_t;

	typedef struct packed {
		logic              valid;
		logic              all;
		logic [BANK_W-1:0] bank;
	} srs_pre_t;

endpackage

// ===== core/srs_since.sv
// Purpose: Saturating cycles-since-event counter
// Assumes: Event pulse from same-clock logic
// Notes:   Reads 1 in the cycle after the event, N after N cycles
`timescale 1ns/1ps
`default_nettype none

module srs_since #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_i,
	input  wire logic             clear_i,
	output logic [WIDTH-1:0]      count_o
);

	logic [WIDTH-1:0] count_reg;

	// Saturated after reset so nothing is blocked at start
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			count_reg <= '1;
		else if (clear_i)
			count_reg <= WIDTH'(1);
		else if (count_reg != '1)
			count_reg <= count_reg + WIDTH'(1);
	end

	assign count_o = count_reg;

endmodule

`default_nettype wire

// ===== core/srs_refresh_scheduler.sv
// Purpose: Refresh scheduler issuing refresh commands and gating activates
// Assumes: Requests, precharges and self refresh level come from same-clock logic
// Notes:   Activate commands themselves are driven by the user after a grant
`timescale 1ns/1ps
`default_nettype none

module srs_refresh_scheduler #(
	parameter int WIN_COOL_CYC  = srs_pkg::REFW_COOL_CYC,
	parameter int WIN_HOT_CYC   = srs_pkg::REFW_HOT_CYC,
	parameter int ACT_TO_ACT_NS = 10
) (
	input  wire logic                          clk_sys_i,
	input  wire logic                          reset_i,
	input  wire logic [2:0]                    temp_rate_i,
	input  wire logic                          burst_mode_i,
	input  wire logic                          per_bank_mode_i,
	input  wire logic                          sr_active_i,
	input  wire srs_pkg::srs_act_t             act_req_i,
	output logic                               act_grant_o,
	input  wire srs_pkg::srs_pre_t             pre_i,
	output logic                               sr_ok_o,
	output srs_pkg::srs_cmd_t                  cmd_o,
	output logic [srs_pkg::BANK_W-1:0]         pb_target_o,
	output logic                               in_pause_o,
	output logic                               deficit_o
);

	localparam logic [srs_pkg::SINCE_W-1:0] RRD_CNT = srs_pkg::SINCE_W'(
		(ACT_TO_ACT_NS + srs_pkg::CLK_PERIOD_NS - 1) / srs_pkg::CLK_PERIOD_NS);

	// ==========================================================
	// Separation trackers
	logic [srs_pkg::SINCE_W-1:0] since_ab;
	logic [srs_pkg::SINCE_W-1:0] since_pb;
	logic [srs_pkg::SINCE_W-1:0] since_act;
	logic                        ref_ab;
	logic                        ref_pb;
	logic                        act_go;

	srs_since #(.WIDTH(srs_pkg::SINCE_W)) u_since_ab (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.clear_i   (ref_ab),
		.count_o   (since_ab)
	);

	srs_since #(.WIDTH(srs_pkg::SINCE_W)) u_since_pb (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.clear_i   (ref_pb),
		.count_o   (since_pb)
	);

	srs_since #(.WIDTH(srs_pkg::SINCE_W)) u_since_act (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.clear_i   (act_go),
		.count_o   (since_act)
	);

	// ==========================================================
	// Bank open state
	logic [srs_pkg::NUM_BANKS-1:0] bank_open_reg;

	genvar gb;
	generate
		for (gb = 0; gb < srs_pkg::NUM_BANKS; gb++)
		begin : g_bank
			// Activate wins over a same-cycle precharge of the bank
			always_ff @(posedge clk_sys_i)
			begin
				if (reset_i)
					bank_open_reg[gb] <= 1'b0;
				else if (act_go && act_req_i.bank == srs_pkg::BANK_W'(gb))
					bank_open_reg[gb] <= 1'b1;
				else if (pre_i.valid && (pre_i.all || pre_i.bank == srs_pkg::BANK_W'(gb)))
					bank_open_reg[gb] <= 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Interval and window timing
	logic                      hot;
	logic [srs_pkg::IVL_W-1:0] ivl_len;
	logic [srs_pkg::IVL_W-1:0] ivl_reg;
	logic                      tick;
	logic [srs_pkg::WIN_W-1:0] win_len;
	logic [srs_pkg::WIN_W-1:0] win_reg;
	logic                      win_end;
	logic                      win_restart;
	logic                      sr_prev_reg;
	logic                      sr_exit;

	assign hot = temp_rate_i > srs_pkg::TEMP_RATE_NOMINAL;
	assign win_len = hot ? srs_pkg::WIN_W'(WIN_HOT_CYC) : srs_pkg::WIN_W'(WIN_COOL_CYC);
	assign ivl_len = per_bank_mode_i ?
		(hot ? srs_pkg::REFI_PB_HOT_CYC : srs_pkg::REFI_PB_COOL_CYC) :
		(hot ? srs_pkg::REFI_AB_HOT_CYC : srs_pkg::REFI_AB_COOL_CYC);
	// Compare with >= so a shorter hot interval takes effect at once
	assign tick    = ivl_reg >= ivl_len - srs_pkg::IVL_W'(1);
	assign win_end = win_reg >= win_len - srs_pkg::WIN_W'(1);
	assign sr_exit = sr_prev_reg && !sr_active_i;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			ivl_reg <= '0;
		else
			ivl_reg <= tick ? '0 : ivl_reg + srs_pkg::IVL_W'(1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || win_restart || win_end)
			win_reg <= '0;
		else
			win_reg <= win_reg + srs_pkg::WIN_W'(1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			sr_prev_reg <= 1'b0;
		else
			sr_prev_reg <= sr_active_i;
	end

	// ==========================================================
	// Pattern phase
	srs_pkg::srs_phase_t          phase_reg;
	logic [srs_pkg::CREDIT_W-1:0] burst_left_reg;
	logic [srs_pkg::OWED_W-1:0]   owed_reg;
	logic                         pause_fresh_reg;

	assign win_restart = (phase_reg == srs_pkg::PH_DIST) && burst_mode_i && !sr_active_i;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			phase_reg <= srs_pkg::PH_DIST;
		else
			case (phase_reg)
				srs_pkg::PH_DIST:
					if (win_restart)
						phase_reg <= srs_pkg::PH_BURST;
				srs_pkg::PH_BURST:
					if (burst_left_reg == '0)
						phase_reg <= burst_mode_i ? srs_pkg::PH_PAUSE : srs_pkg::PH_DIST;
				srs_pkg::PH_PAUSE:
					// Leaving the pause for distributed would starve windows
					if (win_end || sr_exit)
						phase_reg <= srs_pkg::PH_BURST;
				default:
					phase_reg <= srs_pkg::PH_DIST;
			endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			burst_left_reg <= '0;
		else if (win_restart || (phase_reg == srs_pkg::PH_PAUSE && (win_end || sr_exit)))
			burst_left_reg <= srs_pkg::REF_COUNT;
		else if (ref_ab && phase_reg == srs_pkg::PH_BURST)
			burst_left_reg <= burst_left_reg - srs_pkg::CREDIT_W'(1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			pause_fresh_reg <= 1'b0;
		else if (phase_reg == srs_pkg::PH_BURST && burst_left_reg == '0)
			pause_fresh_reg <= 1'b1;
		else if (tick || sr_active_i)
			pause_fresh_reg <= 1'b0;
	end

	// Owed refreshes of the distributed pattern, postponement capped
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || phase_reg != srs_pkg::PH_DIST)
			owed_reg <= '0;
		else if (tick && !sr_active_i && owed_reg != srs_pkg::OWED_MAX && !(ref_ab || ref_pb))
			owed_reg <= owed_reg + srs_pkg::OWED_W'(1);
		else if ((ref_ab || ref_pb) && !(tick && !sr_active_i))
			owed_reg <= owed_reg - srs_pkg::OWED_W'(1);
	end

	// ==========================================================
	// Issue decisions
	logic [srs_pkg::BANK_W-1:0] ptr_reg;
	logic [srs_pkg::BANK_W-1:0] pb_bank_reg;
	logic                       want_ab;
	logic                       want_pb;
	logic                       timers_ok;

	assign timers_ok = since_ab >= srs_pkg::RFC_AB_CYC && since_pb >= srs_pkg::RFC_PB_CYC;
	assign want_ab = !sr_active_i && !sr_exit && since_ab >= srs_pkg::BURST_GAP_CYC &&
		((phase_reg == srs_pkg::PH_DIST && owed_reg != '0 && !per_bank_mode_i) ||
		 (phase_reg == srs_pkg::PH_BURST && burst_left_reg != '0));
	assign want_pb = !sr_active_i && !sr_exit && phase_reg == srs_pkg::PH_DIST &&
		owed_reg != '0 && per_bank_mode_i;
	assign ref_ab = want_ab && timers_ok && bank_open_reg == '0;
	assign ref_pb = want_pb && timers_ok && since_act >= RRD_CNT &&
		!bank_open_reg[ptr_reg];
	// A pending refresh holds off new activates so banks drain
	assign act_go = act_req_i.valid && !sr_active_i && !want_ab && !want_pb &&
		!bank_open_reg[act_req_i.bank] && since_ab >= srs_pkg::RFC_AB_CYC &&
		since_act >= RRD_CNT &&
		(act_req_i.bank == pb_bank_reg ? since_pb >= srs_pkg::RFC_PB_CYC :
		 since_pb >= RRD_CNT);
	assign act_grant_o = act_go;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || ref_ab || sr_exit)
			ptr_reg <= '0;
		else if (ref_pb)
			ptr_reg <= ptr_reg + srs_pkg::BANK_W'(1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			pb_bank_reg <= '0;
		else if (ref_pb)
			pb_bank_reg <= ptr_reg;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			cmd_o <= '{cs_n: 1'b1, ca: srs_pkg::CA_IDLE};
		else if (ref_ab)
			cmd_o <= '{cs_n: 1'b0, ca: srs_pkg::CA_REF_AB};
		else if (ref_pb)
			cmd_o <= '{cs_n: 1'b0, ca: srs_pkg::CA_REF_PB};
		else
			cmd_o <= '{cs_n: 1'b1, ca: srs_pkg::CA_IDLE};
	end

	assign pb_target_o = ptr_reg;
	assign in_pause_o  = phase_reg == srs_pkg::PH_PAUSE;
	assign sr_ok_o = !want_ab && !want_pb && bank_open_reg == '0 && timers_ok &&
		(phase_reg == srs_pkg::PH_DIST || (phase_reg == srs_pkg::PH_PAUSE && pause_fresh_reg));

	// ==========================================================
	// Refresh credit per window
	logic [srs_pkg::CREDIT_W-1:0] credit_reg;
	logic                         credit_inc;

	// Partial self refresh interval credited at exit, i.e. rounded up
	assign credit_inc = ref_ab || (ref_pb && ptr_reg == srs_pkg::LAST_BANK) ||
		(sr_active_i && tick) || sr_exit;

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			credit_reg <= '0;
		else if (win_end || win_restart)
			credit_reg <= srs_pkg::CREDIT_W'(credit_inc);
		else if (credit_inc && credit_reg != '1)
			credit_reg <= credit_reg + srs_pkg::CREDIT_W'(1);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			deficit_o <= 1'b0;
		else if (win_end)
			deficit_o <= credit_reg < srs_pkg::REF_COUNT;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	sequence s_ab;
		ref_ab;
	endsequence

	sequence s_pb;
		ref_pb;
	endsequence

	AST_AB_HOLD: assert property (s_ab |=> (!ref_ab && !ref_pb && !act_go)[*8])
		else $error("refresh or activate too soon after all-bank refresh");
	AST_PB_HOLD: assert property (s_pb |=> (!ref_ab && !ref_pb)[*5])
		else $error("refresh too soon after per-bank refresh");
	AST_PB_ACT: assert property (act_go && act_req_i.bank != pb_bank_reg |->
		since_pb >= RRD_CNT)
		else $error("other-bank activate too soon after per-bank refresh");
	AST_ACT_PB: assert property (s_pb |-> since_act >= RRD_CNT && !bank_open_reg[ptr_reg])
		else $error("per-bank refresh too soon after activate or to open bank");
	AST_ACT_ACT: assert property (act_go |=> since_act == 8'h01 && bank_open_reg[$past(act_req_i.bank)])
		else $error("activate spacing tracker not restarted");
	AST_AB_IDLE: assert property (s_ab |-> bank_open_reg == '0)
		else $error("all-bank refresh with an open bank");
	AST_BURST_GAP: assert property (s_ab |-> $past(since_ab) >= srs_pkg::BURST_GAP_CYC - 8'h01)
		else $error("all-bank refreshes too dense");
	AST_ENCODE: assert property ((ref_ab || ref_pb) |=> !cmd_o.cs_n &&
		cmd_o.ca[srs_pkg::CA_SCOPE_BIT] == $past(ref_ab) && cmd_o.ca[2:0] == 3'h4)
		else $error("refresh command encoding wrong");
	AST_PTR: assert property (s_pb |=> ptr_reg == 3'($past(ptr_reg) + 3'h1))
		else $error("per-bank pointer did not advance");
	AST_DEFER: assert property (phase_reg == srs_pkg::PH_PAUSE && !win_end && !sr_exit |=>
		phase_reg == srs_pkg::PH_PAUSE)
		else $error("pause left before window end");
	AST_SR_OK: assert property (sr_ok_o |-> phase_reg != srs_pkg::PH_BURST)
		else $error("self refresh allowed in burst phase");

endmodule

`default_nettype wire

// ===== verification/srs_dev_model.sv
// Purpose: Device-side model of the refresh logic
// Assumes: Activates seen as grant-qualified requests
// Notes:   Counts any illegal command spacing in bad_o
`timescale 1ns/1ps
`default_nettype none

module srs_dev_model (
	input  wire logic              clk_sys_i,
	input  wire logic              reset_i,
	input  wire srs_pkg::srs_cmd_t cmd_i,
	input  wire srs_pkg::srs_act_t act_i,
	input  wire srs_pkg::srs_pre_t pre_i,
	input  wire logic              sr_active_i,
	output logic [2:0]             ptr_o,
	output logic [15:0]            bad_o
);
	// ==========================================================
	// Spacing limits in 10 ns cycles
	localparam logic [31:0] AB_GAP  = 32'h0000_000D;
	localparam logic [31:0] PB_GAP  = 32'h0000_0006;
	localparam logic [31:0] RRD_GAP = 32'h0000_0001;
	localparam logic [31:0] BW_GAP  = 32'h0000_01A0;

	logic [31:0] cyc_reg;
	logic [31:0] ab_t_reg;
	logic [31:0] pb_t_reg;
	logic [31:0] act_t_reg;
	logic [31:0] hist_reg [8];
	logic [2:0]  hidx_reg;
	logic [7:0]  open_reg;
	logic [2:0]  pb_bank_reg;
	logic        sr_d_reg;
	logic        is_ab;
	logic        is_pb;
	logic        bad;

	// ==========================================================
	// Command decode and legality
	always_comb
	begin
		is_ab = !cmd_i.cs_n && cmd_i.ca == 4'hC;
		is_pb = !cmd_i.cs_n && cmd_i.ca == 4'h4;
		bad = !cmd_i.cs_n && !is_ab && !is_pb;
		if (is_ab && (cyc_reg - ab_t_reg < AB_GAP || cyc_reg - pb_t_reg < PB_GAP
			|| open_reg != 8'h0 || cyc_reg - hist_reg[hidx_reg] < BW_GAP))
			bad = 1'b1;
		if (is_pb && (cyc_reg - ab_t_reg < AB_GAP || cyc_reg - pb_t_reg < PB_GAP
			|| cyc_reg - act_t_reg < RRD_GAP || open_reg[ptr_o]))
			bad = 1'b1;
		if (act_i.valid && (cyc_reg - ab_t_reg < AB_GAP || open_reg[act_i.bank]
			|| cyc_reg - act_t_reg < RRD_GAP || cyc_reg - pb_t_reg <
			(act_i.bank == pb_bank_reg ? PB_GAP : RRD_GAP)))
			bad = 1'b1;
	end

	// ==========================================================
	// Bank state, pointer and history
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			cyc_reg <= 32'h0000_1000;
			ab_t_reg <= 32'h0;
			pb_t_reg <= 32'h0;
			act_t_reg <= 32'h0;
			for (int i = 0; i < 8; i++)
				hist_reg[i] <= 32'h0;
			hidx_reg <= 3'h0;
			open_reg <= 8'h0;
			pb_bank_reg <= 3'h0;
			sr_d_reg <= 1'b0;
			ptr_o <= 3'h0;
			bad_o <= 16'h0;
		end
		else
		begin
			cyc_reg <= cyc_reg + 32'h1;
			sr_d_reg <= sr_active_i;
			if (bad)
				bad_o <= bad_o + 16'h1;
			if (is_ab)
			begin
				ab_t_reg <= cyc_reg;
				hist_reg[hidx_reg] <= cyc_reg;
				hidx_reg <= hidx_reg + 3'h1;
			end
			if (is_pb)
			begin
				pb_t_reg <= cyc_reg;
				pb_bank_reg <= ptr_o;
			end
			if (is_ab || (sr_d_reg && !sr_active_i))
				ptr_o <= 3'h0;
			else if (is_pb)
				ptr_o <= ptr_o + 3'h1;
			if (pre_i.valid)
				open_reg <= pre_i.all ? 8'h0 : open_reg & ~(8'h1 << pre_i.bank);
			if (act_i.valid)
			begin
				act_t_reg <= cyc_reg;
				open_reg[act_i.bank] <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// ===== verification/sdram_refresh_scheduling_tb.sv
// Purpose: Self-checking bench for the refresh scheduler
// Assumes: Short windows so a window end is seen
// Notes:   Burst phase runs last; it never ends in this run
`timescale 1ns/1ps
`default_nettype none

module sdram_refresh_scheduling_tb;
	logic              clk;
	logic              rst;
	logic [2:0]        temp_rate;
	logic              burst_mode;
	logic              per_bank;
	logic              sr_active;
	srs_pkg::srs_act_t act_req;
	srs_pkg::srs_act_t act_seen;
	srs_pkg::srs_pre_t pre;
	logic              act_grant;
	logic              sr_ok;
	srs_pkg::srs_cmd_t cmd;
	logic [2:0]        pb_target;
	logic              in_pause;
	logic              deficit;
	logic [2:0]        dev_ptr;
	logic [15:0]       dev_bad;
	int                failures;
	int                check_count;
	int                cycles;
	int                ref_seen;
	int                last_ref;
	int                g;
	int                t;
	int                n0;

	// User logic registers the grant into its ACT slot, like cmd_o
	always @(posedge clk)
	begin
		if (rst)
			act_seen <= '0;
		else
			act_seen <= {act_req.valid & act_grant, act_req.bank};
	end

	srs_refresh_scheduler #(.WIN_COOL_CYC(20000), .WIN_HOT_CYC(5000), .ACT_TO_ACT_NS(10)) dut_u (
		.clk_sys_i(clk), .reset_i(rst), .temp_rate_i(temp_rate), .burst_mode_i(burst_mode),
		.per_bank_mode_i(per_bank), .sr_active_i(sr_active), .act_req_i(act_req),
		.act_grant_o(act_grant), .pre_i(pre), .sr_ok_o(sr_ok), .cmd_o(cmd),
		.pb_target_o(pb_target), .in_pause_o(in_pause), .deficit_o(deficit));

	srs_dev_model dev_u (.clk_sys_i(clk), .reset_i(rst), .cmd_i(cmd), .act_i(act_seen),
		.pre_i(pre), .sr_active_i(sr_active), .ptr_o(dev_ptr), .bad_o(dev_bad));

	// ==========================================================
	// Clock, cycle count and hang guard
	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles++;
		if (cmd.cs_n === 1'b0)
			ref_seen++;
		if (cycles == 30000)
		begin
			failures++;
			finish_test;
		end
	end

	// ==========================================================
	// Shared tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wait_ref(input logic [3:0] ca);
		int n;
		n = 0;
		do
		begin
			step(1);
			n++;
		end
		while (cmd !== {1'b0, ca} && n < 1000);
		check(32'(n < 1000), 32'h1);
		last_ref = cycles;
	endtask

	task ref_gap(input logic [3:0] ca);
		int t0;
		wait_ref(ca);
		wait_ref(ca);
		t0 = last_ref;
		wait_ref(ca);
		g = last_ref - t0;
	endtask

	task activate(input logic [2:0] b);
		int n;
		n = 0;
		act_req = {1'b1, b};
		while (n < 2000)
		begin
			@(negedge clk);
			if (act_grant === 1'b1)
				break;
			n++;
		end
		check(32'(n < 2000), 32'h1);
		// ACT reaches the bus one cycle after its grant
		t = cycles + 1;
		step(1);
		act_req = '0;
	endtask

	task close(input logic [2:0] b);
		// Keep the precharge off the cycle in which the ACT is on the bus
		step(1);
		pre = {1'b1, 1'b0, b};
		step(1);
		pre = '0;
	endtask

	task finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		check(32'(cmd), 32'h10);
		check(32'(pb_target), 32'h0);
		check(32'(in_pause), 32'h0);
		check(32'(deficit), 32'h0);
		check(32'(sr_ok), 32'h1);
	endtask

	task t_allbank;
		ref_gap(srs_pkg::CA_REF_AB);
		check(32'(g), 32'h186);
		activate(3'h2);
		check(32'(t - last_ref >= 13), 32'h1);
		close(3'h2);
	endtask

	task t_open;
		int t0;
		activate(3'h5);
		n0 = ref_seen;
		step(900);
		check(32'(ref_seen - n0), 32'h0);
		close(3'h5);
		wait_ref(srs_pkg::CA_REF_AB);
		t0 = last_ref;
		wait_ref(srs_pkg::CA_REF_AB);
		check(32'(last_ref - t0), 32'h35);
	endtask

	task t_perbank;
		per_bank = 1'b1;
		for (int k = 0; k < 9; k++)
		begin
			wait_ref(srs_pkg::CA_REF_PB);
			step(2);
			check(32'(pb_target), 32'((k + 1) % 8));
			check(32'(dev_ptr), 32'((k + 1) % 8));
		end
		ref_gap(srs_pkg::CA_REF_PB);
		check(32'(g), 32'h30);
		temp_rate = 3'h4;
		ref_gap(srs_pkg::CA_REF_PB);
		check(32'(g), 32'hC);
		per_bank = 1'b0;
		ref_gap(srs_pkg::CA_REF_AB);
		check(32'(g), 32'h61);
		temp_rate = 3'h3;
	endtask

	task t_selfref;
		per_bank = 1'b1;
		do
		begin
			wait_ref(srs_pkg::CA_REF_PB);
			step(2);
		end
		while (pb_target === 3'h0);
		sr_active = 1'b1;
		act_req = {1'b1, 3'h1};
		n0 = ref_seen;
		step(500);
		check(32'(act_grant), 32'h0);
		check(32'(ref_seen - n0), 32'h0);
		act_req = '0;
		sr_active = 1'b0;
		// One edge only: a held-off refresh may follow right after exit
		step(1);
		check(32'(pb_target), 32'h0);
		check(32'(dev_ptr), 32'h0);
		wait_ref(srs_pkg::CA_REF_PB);
		step(2);
		check(32'(pb_target), 32'h1);
	endtask

	task t_burst;
		per_bank = 1'b0;
		while (cycles < 21000)
			step(100);
		check(32'(deficit), 32'h1);
		burst_mode = 1'b1;
		ref_gap(srs_pkg::CA_REF_AB);
		check(32'(g), 32'h35);
		check(32'(in_pause), 32'h0);
		check(32'(sr_ok), 32'h0);
		check(32'(dev_bad), 32'h0);
	endtask

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		temp_rate = 3'h3;
		burst_mode = 1'b0;
		per_bank = 1'b0;
		sr_active = 1'b0;
		act_req = '0;
		pre = '0;
		failures = 0;
		check_count = 0;
		cycles = 0;
		ref_seen = 0;
		last_ref = 0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		step(1);
		t_reset;
		t_allbank;
		t_open;
		t_perbank;
		t_selfref;
		t_burst;
		finish_test;
	end
endmodule

`default_nettype wire
